// file: verilog/dscr_pkg.sv
package dscr_pkg;

  // ----------------------------------------------------------------
  // Register map (printed index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SETUP_ONE = 6'h01;
  localparam logic [5:0] IDX_SETUP_TWO = 6'h02;
  localparam logic [5:0] IDX_SETUP_THREE = 6'h03;
  localparam logic [5:0] IDX_STATUS = 6'h10;
  localparam int ADDR_W = 8;

  localparam logic [7:0] RST_SETUP_ONE = 8'h03;
  localparam logic [7:0] RST_SETUP_TWO = 8'h20;
  localparam logic [7:0] RST_SETUP_THREE = 8'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_EN = 0;
  localparam int B_CDS = 1;
  localparam int B_SINGLE = 2;
  localparam int B_DUAL = 3;
  localparam int B_OFS_LO = 4;
  localparam int B_FAST4 = 6;
  localparam int B_COMPAT = 7;
  localparam int B_FMT_LO = 0;
  localparam int B_INV = 2;
  localparam int B_OPD = 3;
  localparam int B_CHAN_LO = 6;

  // ----------------------------------------------------------------
  // Encodings and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_FULL_POS = 2'b10;
  localparam logic [1:0] OFS_FULL_NEG = 2'b11;
  localparam logic [1:0] FMT_PAR8 = 2'b01;
  localparam logic [1:0] FMT_NIB4 = 2'b11;
  localparam logic [16:0] CODE_MID = 17'h07fff;
  localparam logic [16:0] CODE_TOP = 17'h0ffff;
  localparam logic [16:0] CODE_ZERO = 17'h00000;
  localparam logic [1:0] LAST_BYTE = 2'd1;
  localparam logic [1:0] LAST_NIB = 2'd3;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } dscr_state_t;

  // Decoded setup, carried as one bundle
  typedef struct packed {
    logic active;
    logic cds;
    logic compat;
    logic fast4;
    logic [1:0] ofs;
    logic [1:0] fmt;
    logic invert;
    logic output_disable_bit;
    logic [2:0] chan_on;
  } dscr_cfg_t;

endpackage

// file: verilog/dscr_regs.sv
// Operation
// [RQ1] Enable bit clear powers everything down; set leaves channels on per mode.
// [RQ2] Setup-one bit 1 picks single-ended (0) or correlated double sampling (1).
// [RQ3] Single-input bit set keeps only the selected channel powered.
// [RQ4] Dual-input bit set keeps red and green, powers blue down.
// [RQ5] Offset field 0x maps zero input to code 32767.
// [RQ6] Offset field 10 maps zero input to code 65535.
// [RQ7] Offset field 11 maps zero input to code zero.
// [RQ8] Software sets inversion for zero code with negative-going video.
// [RQ9] Fastest-mode bit only counts while compatibility timing is on.
// [RQ10] Setup-one bit 7 selects compatibility timing, double-rate clock needed.
// [RQ11] Compatibility timing gives reset-sample pin the clamp and auto-cycle role.
// [RQ12] Format x0 sends each result as two bytes, high first.
// [RQ13] Format 01 sends only the upper byte of each result.
// [RQ14] Format 11 sends four nibbles; valid only under compatibility timing.
// [RQ15] Setup-two bit 2 inverts output data polarity.
// [RQ16] Output pins driven only when enable pin low and disable bit clear.
// [RQ17] Setup-three bits 7:6 choose the channel in single-input operation.
//
// The APB interface to the registers was decided locally.
module dscr_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dscr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter result
  input wire logic [15:0] adc_diff,
  input wire logic adc_valid,
  // Output port pins
  input wire logic output_enable_pin_n,
  output logic [7:0] op_data,
  output logic op_data_oe_n,
  output logic op_strobe,
  // Analogue and timing steering
  output logic chip_active,
  output logic cds_sel,
  output logic compat_timing,
  output logic compat_fastest,
  output logic reset_sample_pin_compat,
  output logic [2:0] chan_power_on
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] setup_one_mode_control;
  logic [7:0] setup_two_output_control;
  logic [7:0] setup_three;
  logic [7:0] next_one, next_two, next_three;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  dscr_pkg::dscr_cfg_t cfg;
  dscr_pkg::dscr_state_t state, next_state;

  function automatic logic is_reg(input logic [dscr_pkg::ADDR_W-1:0] a,
                                  input logic [5:0] idx);
    is_reg = (a == {idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [dscr_pkg::ADDR_W-1:0] a);
    mapped = is_reg(a, dscr_pkg::IDX_SETUP_ONE) | is_reg(a, dscr_pkg::IDX_SETUP_TWO)
           | is_reg(a, dscr_pkg::IDX_SETUP_THREE) | is_reg(a, dscr_pkg::IDX_STATUS);
  endfunction

  wire logic wr_go = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    next_one = setup_one_mode_control;
    next_two = setup_two_output_control;
    next_three = setup_three;
    if (wr_go && is_reg(paddr, dscr_pkg::IDX_SETUP_ONE)) begin
      next_one = pwdata[7:0];
    end
    if (wr_go && is_reg(paddr, dscr_pkg::IDX_SETUP_TWO)) begin
      next_two = pwdata[7:0];
    end
    if (wr_go && is_reg(paddr, dscr_pkg::IDX_SETUP_THREE)) begin
      next_three = pwdata[7:0];
    end
  end

  // One wait state: answer in the second access cycle
  always_comb begin
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~mapped(paddr);
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready && !pwrite) begin
      if (is_reg(paddr, dscr_pkg::IDX_SETUP_ONE)) begin
        next_prdata = {24'h00_0000, setup_one_mode_control};
      end else if (is_reg(paddr, dscr_pkg::IDX_SETUP_TWO)) begin
        next_prdata = {24'h00_0000, setup_two_output_control};
      end else if (is_reg(paddr, dscr_pkg::IDX_SETUP_THREE)) begin
        next_prdata = {24'h00_0000, setup_three};
      end else if (is_reg(paddr, dscr_pkg::IDX_STATUS)) begin
        next_prdata = {24'h00_0000, op_data_oe_n, state == dscr_pkg::ST_SEND,
                       chip_active, compat_timing, compat_fastest, chan_power_on};
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      setup_one_mode_control <= dscr_pkg::RST_SETUP_ONE;
      setup_two_output_control <= dscr_pkg::RST_SETUP_TWO;
      setup_three <= dscr_pkg::RST_SETUP_THREE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      setup_one_mode_control <= next_one;
      setup_two_output_control <= next_two;
      setup_three <= next_three;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [2:0] sel_mask;
  always_comb begin
    cfg.active = setup_one_mode_control[dscr_pkg::B_EN]; // RQ1
    cfg.cds = setup_one_mode_control[dscr_pkg::B_CDS]; // RQ2
    cfg.compat = setup_one_mode_control[dscr_pkg::B_COMPAT]; // RQ10
    // Ignored outside compatibility timing
    cfg.fast4 = setup_one_mode_control[dscr_pkg::B_FAST4] & cfg.compat; // RQ9
    cfg.ofs = setup_one_mode_control[dscr_pkg::B_OFS_LO +: 2];
    cfg.fmt = setup_two_output_control[dscr_pkg::B_FMT_LO +: 2];
    cfg.invert = setup_two_output_control[dscr_pkg::B_INV];
    cfg.output_disable_bit = setup_two_output_control[dscr_pkg::B_OPD];
    // Select code 11 has no fourth input; it falls back to red
    case (setup_three[dscr_pkg::B_CHAN_LO +: 2]) // RQ17
      2'b01: sel_mask = 3'b010;
      2'b10: sel_mask = 3'b100;
      default: sel_mask = 3'b001;
    endcase
    if (!cfg.active) begin
      cfg.chan_on = 3'b000; // RQ1
    end else if (setup_one_mode_control[dscr_pkg::B_SINGLE]) begin
      cfg.chan_on = sel_mask; // RQ3
    end else if (setup_one_mode_control[dscr_pkg::B_DUAL]) begin
      cfg.chan_on = 3'b011; // RQ4
    end else begin
      cfg.chan_on = 3'b111;
    end
  end

  // ----------------------------------------------------------------
  // Output code and serialiser
  // ----------------------------------------------------------------
  logic [15:0] word, next_word;
  logic [1:0] phase, next_phase;
  logic [7:0] next_op_data;
  logic next_strobe, next_oe_n;
  logic [16:0] base, sum;
  logic [15:0] code;

  always_comb begin
    case (cfg.ofs)
      dscr_pkg::OFS_FULL_POS: base = dscr_pkg::CODE_TOP; // RQ6
      dscr_pkg::OFS_FULL_NEG: base = dscr_pkg::CODE_ZERO; // RQ7
      default: base = dscr_pkg::CODE_MID; // RQ5
    endcase
    // Signed input added with saturation at both rails
    sum = 17'(base + {{1{adc_diff[15]}}, adc_diff});
    if (adc_diff[15] && base < 17'(-$signed({adc_diff[15], adc_diff}))) begin
      code = 16'h0000;
    end else if (!adc_diff[15] && sum > dscr_pkg::CODE_TOP) begin
      code = 16'hffff;
    end else begin
      code = sum[15:0];
    end
    if (cfg.invert) begin
      code = ~code; // RQ15
    end
  end

  // Nibble format is honoured only under compatibility timing
  wire logic nib_mode = (cfg.fmt == dscr_pkg::FMT_NIB4) & cfg.compat; // RQ14
  wire logic par_mode = (cfg.fmt == dscr_pkg::FMT_PAR8);

  always_comb begin
    next_state = state;
    next_word = word;
    next_phase = phase;
    next_op_data = op_data;
    next_strobe = 1'b0;
    next_oe_n = output_enable_pin_n | cfg.output_disable_bit; // RQ16
    case (state)
      dscr_pkg::ST_IDLE: begin
        if (adc_valid && cfg.active) begin
          next_strobe = 1'b1;
          next_phase = 2'd0;
          if (par_mode) begin
            next_op_data = code[15:8]; // RQ13
          end else if (nib_mode) begin
            next_op_data = {4'h0, code[15:12]}; // RQ14
            next_word = {code[11:0], 4'h0};
            next_state = dscr_pkg::ST_SEND;
          end else begin
            next_op_data = code[15:8]; // RQ12
            next_word = {code[7:0], 8'h00};
            next_state = dscr_pkg::ST_SEND;
          end
        end
      end
      dscr_pkg::ST_SEND: begin
        next_strobe = 1'b1;
        next_phase = 2'(phase + 2'd1);
        if (nib_mode) begin
          next_op_data = {4'h0, word[15:12]};
          next_word = {word[11:0], 4'h0};
          if (next_phase == dscr_pkg::LAST_NIB) begin
            next_state = dscr_pkg::ST_IDLE;
          end
        end else begin
          next_op_data = word[15:8];
          next_word = {word[7:0], 8'h00};
          if (next_phase == dscr_pkg::LAST_BYTE) begin
            next_state = dscr_pkg::ST_IDLE;
          end
        end
      end
      default: next_state = dscr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= dscr_pkg::ST_IDLE;
      word <= 16'h0000;
      phase <= 2'd0;
      op_data <= 8'h00;
      op_strobe <= 1'b0;
      op_data_oe_n <= 1'b1;
      chip_active <= 1'b0;
      cds_sel <= 1'b0;
      compat_timing <= 1'b0;
      compat_fastest <= 1'b0;
      reset_sample_pin_compat <= 1'b0;
      chan_power_on <= 3'b000;
    end else begin
      state <= next_state;
      word <= next_word;
      phase <= next_phase;
      op_data <= next_op_data;
      op_strobe <= next_strobe;
      op_data_oe_n <= next_oe_n;
      chip_active <= cfg.active;
      cds_sel <= cfg.cds;
      compat_timing <= cfg.compat;
      compat_fastest <= cfg.fast4;
      reset_sample_pin_compat <= cfg.compat; // RQ11
      chan_power_on <= cfg.chan_on;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Burst end judged by state: a result taken at once after it stays legal
  sequence two_byte_burst;
    (op_strobe && state == dscr_pkg::ST_SEND) ##1 (op_strobe && state == dscr_pkg::ST_IDLE);
  endsequence

  sequence nib_burst;
    (op_strobe && state == dscr_pkg::ST_SEND) [*3] ##1
      (op_strobe && state == dscr_pkg::ST_IDLE);
  endsequence

  power_down_a: assert property (!cfg.active |=> chan_power_on == 3'b000) // RQ1
    else $error("channels on while disabled");
  cds_follow_a: assert property (!$past(reset)
      |-> cds_sel == $past(setup_one_mode_control[1])) // RQ2
    else $error("sampling select mismatch");
  single_chan_a: assert property (cfg.active && setup_one_mode_control[2]
      |=> $countones(chan_power_on) == 1) // RQ3
    else $error("single input powers more than one channel");
  dual_chan_a: assert property (cfg.active && !setup_one_mode_control[2]
      && setup_one_mode_control[3] |=> chan_power_on == 3'b011) // RQ4
    else $error("dual input channel set wrong");
  fast_gate_a: assert property (!compat_timing |-> !compat_fastest) // RQ9
    else $error("fastest bit active outside compatibility");
  oe_gate_a: assert property (output_enable_pin_n || cfg.output_disable_bit |=> op_data_oe_n) // RQ16
    else $error("outputs driven while disabled");
  byte_pair_a: assert property (state == dscr_pkg::ST_IDLE && adc_valid && cfg.active
      && !par_mode && !nib_mode |=> two_byte_burst) // RQ12
    else $error("two-byte burst wrong");
  nib_quad_a: assert property (state == dscr_pkg::ST_IDLE && adc_valid && cfg.active
      && nib_mode |=> nib_burst) // RQ14
    else $error("nibble burst wrong");
  par_byte_a: assert property (state == dscr_pkg::ST_IDLE && adc_valid && cfg.active
      && par_mode ##1 !adc_valid |-> op_strobe ##1 !op_strobe) // RQ13
    else $error("single byte burst wrong");
  mid_code_a: assert property (state == dscr_pkg::ST_IDLE && adc_valid && cfg.active
      && par_mode && !cfg.ofs[1] && !cfg.invert && adc_diff == 16'h0000
      |=> op_data == 8'h7f) // RQ5
    else $error("mid-scale code wrong");

endmodule

// file: sim/dscr_scan_model.sv
module dscr_scan_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Output port
  input wire logic [7:0] op_data,
  input wire logic op_data_oe_n,
  input wire logic op_strobe,
  output logic output_enable_pin_n,
  // Bench side
  input wire logic hold_off,
  input wire logic clr,
  output logic [31:0] cap_word,
  output logic [2:0] cap_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  assign output_enable_pin_n = hold_off;
  // Floating pins are never taken: data counts only while driven
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cap_word <= 32'h0;
      cap_cnt <= 3'h0;
    end else if (clr) begin
      cap_word <= 32'h0;
      cap_cnt <= 3'h0;
    end else if (op_strobe && !op_data_oe_n) begin
      cap_word <= {cap_word[23:0], op_data};
      cap_cnt <= cap_cnt + 3'h1;
    end
  end
endmodule

// file: sim/tb_digitiser_setup_control_regs.sv
module tb_digitiser_setup_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, adc_valid = 1'b0, hold_off = 1'b0, clr = 1'b0;
  logic [15:0] adc_diff = 16'h0;
  logic [7:0] op_data;
  logic op_data_oe_n, op_strobe, oepin, chip_active, cds_sel, compat_timing;
  logic compat_fastest, reset_sample_pin_compat;
  logic [2:0] chan_power_on, cap_cnt;
  logic [31:0] cap_word;
  int err_count = 0, samples_checked = 0, cyc = 0;
  dscr_regs dscr_regs_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_diff(adc_diff), .adc_valid(adc_valid),
    .output_enable_pin_n(oepin), .op_data(op_data), .op_data_oe_n(op_data_oe_n),
    .op_strobe(op_strobe), .chip_active(chip_active), .cds_sel(cds_sel),
    .compat_timing(compat_timing), .compat_fastest(compat_fastest),
    .reset_sample_pin_compat(reset_sample_pin_compat), .chan_power_on(chan_power_on));
  dscr_scan_model dscr_scan_model_inst (.mclk(mclk), .reset(reset), .op_data(op_data),
    .op_data_oe_n(op_data_oe_n), .op_strobe(op_strobe), .output_enable_pin_n(oepin),
    .hold_off(hold_off), .clr(clr), .cap_word(cap_word), .cap_cnt(cap_cnt));
  always #25 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Generous ceiling, the run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    repeat (2) @(posedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk({rd[31:1], er}, {24'h0, e[7:1], ee});
    chk({31'h0, rd[0]}, {31'h0, e[0]});
  endtask
  task automatic cfg(input logic [7:0] s1, input logic [7:0] s3);
    logic [2:0] ch;
    wr(8'h0c, s3);
    wr(8'h04, s1);
    ch = !s1[0] ? 3'b000 : s1[2] ? (s3[7:6] == 2'd1 ? 3'b010 : s3[7:6] == 2'd2 ? 3'b100 :
      3'b001) : s1[3] ? 3'b011 : 3'b111;
    chk({26'h0, chip_active, cds_sel, chan_power_on}, {26'h0, s1[0], s1[1], ch});
    chk({29'h0, compat_timing, compat_fastest, reset_sample_pin_compat},
      {29'h0, s1[7], s1[7] & s1[6], s1[7]});
  endtask
  task automatic pix(input logic [7:0] s1, input logic [7:0] s2, input logic [15:0] d);
    int v, n;
    logic [15:0] c;
    logic [31:0] e;
    wr(8'h04, s1);
    wr(8'h08, s2);
    v = s1[5:4] == 2'b10 ? 65535 : s1[5:4] == 2'b11 ? 0 : 32767;
    v = v + int'($signed(d));
    v = v > 65535 ? 65535 : v < 0 ? 0 : v;
    c = s2[2] ? ~v[15:0] : v[15:0];
    e = s2[1:0] == 2'b01 ? {24'h0, c[15:8]} : s2[1:0] == 2'b11 && s1[7] ?
      {4'h0, c[15:12], 4'h0, c[11:8], 4'h0, c[7:4], 4'h0, c[3:0]} : {16'h0, c};
    n = s2[1:0] == 2'b01 ? 1 : s2[1:0] == 2'b11 && s1[7] ? 4 : 2;
    // Disabled chip or disabled port: nothing reaches the controller
    if (s2[3] || !s1[0]) begin
      e = 32'h0;
      n = 0;
    end
    @(posedge mclk);
    clr <= 1'b1;
    adc_diff <= d;
    adc_valid <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    adc_valid <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(cap_word, e);
    chk({29'h0, cap_cnt}, 32'(n));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rdchk(8'h04, 8'h03, 1'b0);
    rdchk(8'h08, 8'h20, 1'b0);
    rdchk(8'h0c, 8'h1f, 1'b0);
    rdchk(8'h40, 8'h27, 1'b0);
    apb(1'b1, 8'h30, 32'h55);
    chk({31'h0, er}, 32'h1);
    rdchk(8'h30, 8'h00, 1'b1);
    wr(8'h0c, 8'h9f);
    rdchk(8'h0c, 8'h9f, 1'b0);
    cfg(8'h00, 8'h1f);
    cfg(8'h01, 8'h1f);
    cfg(8'h07, 8'h1f);
    cfg(8'h07, 8'h5f);
    cfg(8'h07, 8'h9f);
    cfg(8'h07, 8'hdf);
    cfg(8'h0b, 8'h1f);
    cfg(8'h41, 8'h1f);
    cfg(8'hc1, 8'h1f);
    cfg(8'h81, 8'h1f);
    pix(8'h01, 8'h20, 16'h0000);
    pix(8'h11, 8'h20, 16'hfff0);
    pix(8'h21, 8'h20, 16'h0000);
    pix(8'h21, 8'h20, 16'h0001);
    pix(8'h31, 8'h20, 16'h0000);
    pix(8'h31, 8'h20, 16'hffff);
    pix(8'h21, 8'h24, 16'h0000);
    pix(8'h01, 8'h22, 16'h1234);
    pix(8'h01, 8'h21, 16'h1234);
    pix(8'h01, 8'h21, 16'h0000);
    pix(8'h01, 8'h23, 16'h1234);
    pix(8'h81, 8'h23, 16'h1234);
    pix(8'h01, 8'h28, 16'h1234);
    pix(8'h00, 8'h20, 16'h0000);
    chk({31'h0, op_data_oe_n}, 32'h0);
    hold_off <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, op_data_oe_n}, 32'h1);
    hold_off <= 1'b0;
    wr(8'h08, 8'h28);
    chk({31'h0, op_data_oe_n}, 32'h1);
    complete_run();
  end
endmodule
